// file: logic/rtc_pkg.sv
/*
 Shared constants of the time and date counter block: register offsets,
 reset values, BCD limits, field positions and oscillator timing.
 Assumes a 50 MHz system clock and a 32.768 kHz oscillator clock.
*/
package rtc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_SCRATCH = 8'h03;
	localparam logic [7:0] ADDR_SECONDS = 8'h04;
	localparam logic [7:0] ADDR_MINUTES = 8'h05;
	localparam logic [7:0] ADDR_HOURS = 8'h06;
	localparam logic [7:0] ADDR_DAYS = 8'h07;
	localparam logic [7:0] ADDR_WEEKDAYS = 8'h08;
	localparam logic [7:0] ADDR_MONTHS = 8'h09;
	localparam logic [7:0] ADDR_YEARS = 8'h0A;
	// ==========================================================
	// Reset values and field positions
	localparam logic [7:0] SCRATCH_RST = 8'h00;
	localparam logic [6:0] SEC_RST = 7'h00;
	localparam logic [6:0] MIN_RST = 7'h00;
	localparam logic [5:0] HOUR_RST = 6'h00;
	localparam logic [5:0] DAY_RST = 6'h01;
	localparam logic [2:0] WDAY_RST = 3'h6;
	localparam logic [4:0] MONTH_RST = 5'h01;
	localparam logic [7:0] YEAR_RST = 8'h00;
	localparam int OSF_BIT = 7;
	localparam int MERIDIEM_BIT = 5;
	// ==========================================================
	// BCD limits
	localparam logic [6:0] SEC_MAX = 7'h59;
	localparam logic [5:0] HR24_MAX = 6'h23;
	localparam logic [4:0] HR12_TOP = 5'h12;
	localparam logic [4:0] HR12_PRE = 5'h11;
	localparam logic [4:0] HR12_FIRST = 5'h01;
	localparam logic [5:0] DAY_FIRST = 6'h01;
	localparam logic [5:0] DAYS_28 = 6'h28;
	localparam logic [5:0] DAYS_29 = 6'h29;
	localparam logic [5:0] DAYS_30 = 6'h30;
	localparam logic [5:0] DAYS_31 = 6'h31;
	localparam logic [4:0] MON_FEB = 5'h02;
	localparam logic [4:0] MON_APR = 5'h04;
	localparam logic [4:0] MON_JUN = 5'h06;
	localparam logic [4:0] MON_SEP = 5'h09;
	localparam logic [4:0] MON_NOV = 5'h11;
	localparam logic [4:0] MON_MAX = 5'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [2:0] WDAY_MAX = 3'h6;
	// ==========================================================
	// Oscillator timing and output selections
	localparam int OSC_HZ = 32768;
	localparam int CORR_WIDTH_DIV = 1024;
	localparam int CORR_SPACE_DIV = 512;
	localparam logic [5:0] CORR_WIDTH_CYC = 6'(OSC_HZ / CORR_WIDTH_DIV);
	localparam logic [5:0] CORR_LAST_CYC = 6'(OSC_HZ / CORR_SPACE_DIV - 1);
	localparam logic [5:0] HALF_MIN_A = 6'h1D;
	localparam logic [5:0] HALF_MIN_B = 6'h3B;
	localparam logic [2:0] FREQ_OUTPUT_PIN_1HZ = 3'h6;
	localparam logic [2:0] FREQ_OUTPUT_PIN_OFF = 3'h7;
	localparam int CLK_PERIOD_NS = 20;
	localparam int OSC_PERIOD_NS = 30518;
	localparam int STOP_PERIODS = 4;
	localparam int STOP_TIMEOUT_CYC =
		(STOP_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : rtc_pkg

// file: logic/rtc_osc_divider.sv
/*
 Oscillator-domain prescaler: 1 Hz tick, clock output, timer source
 and fast-mode correction pulses. Assumes osc_clk_in is the 32.768 kHz
 crystal clock and that its control inputs change only rarely.
*/
`timescale 1ns/1ps
module rtc_osc_divider (
	// Clock and reset
	input wire logic osc_clk_in,
	input wire logic rstn_in,
	// Controls from the system domain
	input wire logic fast_mode_in,
	input wire logic [2:0] corr_count_in,
	input wire logic corr_sign_in,
	input wire logic [2:0] freq_output_pin_sel_in,
	input wire logic [1:0] timer_src_sel_in,
	// Crossing signals
	output logic sec_toggle_out,
	output logic alive_out,
	// Pins
	output logic corr_int_n_out,
	output logic freq_out,
	output logic timer_clk_out
);
	// ==========================================================
	// Reset and control synchronisers
	logic rst_s1;
	logic rst_s2;
	logic [9:0] ctl_raw;
	logic [9:0] ctl_s1;
	logic [9:0] ctl;
	logic [7:0] lo;
	logic [6:0] hi;
	logic [7:0] hi_sum;
	logic [1:0] step;
	logic [2:0] adj_cnt;
	logic [2:0] pulses_left;
	logic [5:0] phase;
	logic [5:0] sec_cnt;
	logic min_clk;
	logic lo_wrap;
	logic sec_wrap;
	logic pulse_start;

	// Release is synchronous so no divider flop sees a runt reset
	always_ff @(posedge osc_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	assign ctl_raw = {fast_mode_in, corr_count_in, corr_sign_in, freq_output_pin_sel_in,
		timer_src_sel_in};

	// Two flops per control bit
	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_sync
			always_ff @(posedge osc_clk_in or negedge rst_s2) begin
				if (!rst_s2) begin
					ctl_s1[g] <= 1'b0;
					ctl[g] <= 1'b0;
				end else begin
					ctl_s1[g] <= ctl_raw[g];
					ctl[g] <= ctl_s1[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Prescaler; corrections only bend the upper stage
	assign lo_wrap = (lo == 8'hFF);
	assign step = (adj_cnt != 3'h0) ? (ctl[5] ? 2'h2 : 2'h0) : 2'h1;
	assign hi_sum = {1'b0, hi} + {6'h00, step};
	assign sec_wrap = lo_wrap & hi_sum[7];
	assign pulse_start = (pulses_left != 3'h0) && (phase == 6'h00);

	always_ff @(posedge osc_clk_in or negedge rst_s2) begin
		if (!rst_s2) begin
			lo <= 8'h00;
			hi <= 7'h00;
			sec_toggle_out <= 1'b0;
			sec_cnt <= 6'h00;
			min_clk <= 1'b0;
		end else begin
			lo <= lo + 8'h01;
			if (lo_wrap) begin
				hi <= hi_sum[6:0];
			end
			if (sec_wrap) begin
				sec_toggle_out <= ~sec_toggle_out;
				sec_cnt <= (sec_cnt == rtc_pkg::HALF_MIN_B) ? 6'h00 : sec_cnt + 6'h01;
				if (sec_cnt == rtc_pkg::HALF_MIN_A ||
					sec_cnt == rtc_pkg::HALF_MIN_B) begin
					min_clk <= ~min_clk;
				end
			end
		end
	end

	// ==========================================================
	// Correction pulses, counted in oscillator periods
	always_ff @(posedge osc_clk_in or negedge rst_s2) begin
		if (!rst_s2) begin
			pulses_left <= 3'h0;
			phase <= 6'h00;
			adj_cnt <= 3'h0;
		end else begin
			if (sec_wrap) begin
				pulses_left <= ctl[9] ? ctl[8:6] : 3'h0;
				phase <= 6'h00;
			end else if (pulses_left != 3'h0) begin
				phase <= phase + 6'h01;
				if (phase == rtc_pkg::CORR_LAST_CYC) begin
					pulses_left <= pulses_left - 3'h1;
				end
			end
			// A new pulse and a consumed one in the same edge cancel out
			if (pulse_start && !lo_wrap) begin
				adj_cnt <= adj_cnt + 3'h1;
			end else if (!pulse_start && lo_wrap && adj_cnt != 3'h0) begin
				adj_cnt <= adj_cnt - 3'h1;
			end
		end
	end

	// ==========================================================
	// Registered pins
	always_ff @(posedge osc_clk_in or negedge rst_s2) begin
		if (!rst_s2) begin
			corr_int_n_out <= 1'b1;
			freq_out <= 1'b0;
			timer_clk_out <= 1'b0;
			alive_out <= 1'b0;
		end else begin
			alive_out <= ~alive_out;
			corr_int_n_out <= ~((pulses_left != 3'h0) &&
				(phase < rtc_pkg::CORR_WIDTH_CYC));
			// Fast rates come from the untouched lower stage
			if (ctl[4:2] == rtc_pkg::FREQ_OUTPUT_PIN_1HZ) begin
				freq_out <= hi[6];
			end else if (ctl[4:2] == rtc_pkg::FREQ_OUTPUT_PIN_OFF) begin
				freq_out <= 1'b0;
			end else if (ctl[4:2] == 3'h0) begin
				freq_out <= lo[0];
			end else begin
				freq_out <= lo[ctl[4:2] - 3'h1];
			end
			unique case (ctl[1:0])
				2'h0: timer_clk_out <= lo[2];
				2'h1: timer_clk_out <= hi[0];
				2'h2: timer_clk_out <= hi[6];
				2'h3: timer_clk_out <= min_clk;
			endcase
		end
	end
endmodule : rtc_osc_divider

// file: logic/rtc_time_date_counters.sv
/*
 Time, calendar and scratch registers of a small real-time clock,
 with oscillator stop detection and the oscillator-domain prescaler.
 Assumes a bus engine on clk_in that holds access_active_in high for a
 whole bus access and gives one-cycle write strobes with an address.
*/
`timescale 1ns/1ps
module rtc_time_date_counters #(
	parameter int unsigned STOP_TIMEOUT = rtc_pkg::STOP_TIMEOUT_CYC
) (
	// Clocks and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic osc_clk_in,
	// Register port of the bus engine
	input wire logic access_active_in,
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out,
	// Control bits held in other registers
	input wire logic hour_12_mode_in,
	input wire logic fast_mode_in,
	input wire logic [2:0] corr_count_in,
	input wire logic corr_sign_in,
	input wire logic [2:0] freq_output_pin_sel_in,
	input wire logic [1:0] timer_src_sel_in,
	// Pins and status
	output logic corr_int_n_out,
	output logic freq_output_pin_out,
	output logic timer_clk_out,
	output logic osc_stopped_flag_out
);
	// ==========================================================
	// Declarations
	logic [7:0] scratch_byte;
	logic [6:0] seconds_count;
	logic [6:0] minutes_count;
	logic [5:0] hours_count;
	logic [5:0] day_of_month;
	logic [2:0] day_of_week;
	logic [4:0] month_count;
	logic [7:0] year_count;
	logic [6:0] next_seconds;
	logic [6:0] next_minutes;
	logic [5:0] next_hours;
	logic [5:0] next_day;
	logic [2:0] next_weekday;
	logic [4:0] next_month;
	logic [7:0] next_year;
	logic sec_toggle;
	logic alive;
	logic tick_s1;
	logic tick_s2;
	logic tick_s3;
	logic alive_s1;
	logic alive_s2;
	logic alive_s3;
	logic tick;
	logic tick_pending;
	logic do_inc;
	logic [15:0] stop_cnt;
	logic osc_stopped;
	logic leap_year;
	logic [5:0] month_len;
	logic wr_sec;

	// ==========================================================
	// Oscillator domain
	rtc_osc_divider u_osc (
		.osc_clk_in(osc_clk_in),
		.rstn_in(rstn_in),
		.fast_mode_in(fast_mode_in),
		.corr_count_in(corr_count_in),
		.corr_sign_in(corr_sign_in),
		.freq_output_pin_sel_in(freq_output_pin_sel_in),
		.timer_src_sel_in(timer_src_sel_in),
		.sec_toggle_out(sec_toggle),
		.alive_out(alive),
		.corr_int_n_out(corr_int_n_out),
		.freq_out(freq_output_pin_out),
		.timer_clk_out(timer_clk_out)
	);

	// ==========================================================
	// Crossings: second toggle and oscillator heartbeat
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_s1 <= 1'b0;
			tick_s2 <= 1'b0;
			tick_s3 <= 1'b0;
			alive_s1 <= 1'b0;
			alive_s2 <= 1'b0;
			alive_s3 <= 1'b0;
		end else begin
			tick_s1 <= sec_toggle;
			tick_s2 <= tick_s1;
			tick_s3 <= tick_s2;
			alive_s1 <= alive;
			alive_s2 <= alive_s1;
			alive_s3 <= alive_s2;
		end
	end

	assign tick = tick_s2 ^ tick_s3;

	// One tick is kept while an access blocks the counters
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_pending <= 1'b0;
		end else begin
			tick_pending <= tick | (tick_pending & access_active_in);
		end
	end

	assign do_inc = tick_pending & ~access_active_in;

	// ==========================================================
	// Oscillator stop watchdog
	// Starts out expired so the power-on interval already reads stopped
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stop_cnt <= 16'(STOP_TIMEOUT);
		end else if (alive_s2 ^ alive_s3) begin
			stop_cnt <= 16'h0000;
		end else if (stop_cnt != 16'(STOP_TIMEOUT)) begin
			stop_cnt <= stop_cnt + 16'h0001;
		end
	end

	assign osc_stopped = (stop_cnt == 16'(STOP_TIMEOUT));

	// Set wins over a clear, so a stopped oscillator reads back 1
	assign wr_sec = wr_en_in && (addr_in == rtc_pkg::ADDR_SECONDS);
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			osc_stopped_flag_out <= 1'b1;
		end else if (osc_stopped) begin
			osc_stopped_flag_out <= 1'b1;
		end else if (wr_sec) begin
			osc_stopped_flag_out <= wr_data_in[rtc_pkg::OSF_BIT];
		end
	end

	// ==========================================================
	// Calendar helpers
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_inc

	// Even tens with units 0/4/8, or odd tens with units 2/6
	assign leap_year = year_count[4] ?
		(year_count[3:0] == 4'h2 || year_count[3:0] == 4'h6) :
		(year_count[3:0] == 4'h0 || year_count[3:0] == 4'h4 ||
		year_count[3:0] == 4'h8);

	always_comb begin
		if (month_count == rtc_pkg::MON_FEB) begin
			month_len = leap_year ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
		end else if (month_count == rtc_pkg::MON_APR || month_count == rtc_pkg::MON_JUN ||
			month_count == rtc_pkg::MON_SEP || month_count == rtc_pkg::MON_NOV) begin
			month_len = rtc_pkg::DAYS_30;
		end else begin
			month_len = rtc_pkg::DAYS_31;
		end
	end

	// ==========================================================
	// Carry chain for one second
	always_comb begin
		logic [7:0] t;
		logic carry;
		t = 8'h00;
		carry = do_inc;
		next_seconds = seconds_count;
		next_minutes = minutes_count;
		next_hours = hours_count;
		next_day = day_of_month;
		next_weekday = day_of_week;
		next_month = month_count;
		next_year = year_count;
		if (carry) begin
			carry = (seconds_count == rtc_pkg::SEC_MAX);
			t = bcd_inc({1'b0, seconds_count});
			next_seconds = carry ? rtc_pkg::SEC_RST : t[6:0];
		end
		if (carry) begin
			carry = (minutes_count == rtc_pkg::SEC_MAX);
			t = bcd_inc({1'b0, minutes_count});
			next_minutes = carry ? rtc_pkg::MIN_RST : t[6:0];
		end
		if (carry && hour_12_mode_in) begin
			carry = 1'b0;
			t = bcd_inc({3'h0, hours_count[4:0]});
			if (hours_count[4:0] == rtc_pkg::HR12_TOP) begin
				next_hours = {hours_count[5], rtc_pkg::HR12_FIRST};
			end else if (hours_count[4:0] == rtc_pkg::HR12_PRE) begin
				next_hours = {~hours_count[5], rtc_pkg::HR12_TOP};
				carry = hours_count[rtc_pkg::MERIDIEM_BIT];
			end else begin
				next_hours = {hours_count[5], t[4:0]};
			end
		end else if (carry) begin
			carry = (hours_count == rtc_pkg::HR24_MAX);
			t = bcd_inc({2'h0, hours_count});
			next_hours = carry ? rtc_pkg::HOUR_RST : t[5:0];
		end
		if (carry) begin
			next_weekday = (day_of_week == rtc_pkg::WDAY_MAX) ? 3'h0 :
				day_of_week + 3'h1;
			carry = (day_of_month == month_len);
			t = bcd_inc({2'h0, day_of_month});
			next_day = carry ? rtc_pkg::DAY_FIRST : t[5:0];
		end
		if (carry) begin
			carry = (month_count == rtc_pkg::MON_MAX);
			t = bcd_inc({3'h0, month_count});
			next_month = carry ? rtc_pkg::MONTH_RST : t[4:0];
		end
		if (carry) begin
			t = bcd_inc(year_count);
			next_year = (year_count == rtc_pkg::YEAR_MAX) ? rtc_pkg::YEAR_RST : t;
		end
	end

	// ==========================================================
	// Time registers: host writes or the carry chain
	// Counting never runs during an access, so the two cannot collide
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			seconds_count <= rtc_pkg::SEC_RST;
			minutes_count <= rtc_pkg::MIN_RST;
			hours_count <= rtc_pkg::HOUR_RST;
			day_of_month <= rtc_pkg::DAY_RST;
			day_of_week <= rtc_pkg::WDAY_RST;
			month_count <= rtc_pkg::MONTH_RST;
			year_count <= rtc_pkg::YEAR_RST;
		end else if (wr_en_in) begin
			unique case (addr_in)
				rtc_pkg::ADDR_SECONDS: seconds_count <= wr_data_in[6:0];
				rtc_pkg::ADDR_MINUTES: minutes_count <= wr_data_in[6:0];
				rtc_pkg::ADDR_HOURS: hours_count <= wr_data_in[5:0];
				rtc_pkg::ADDR_DAYS: day_of_month <= wr_data_in[5:0];
				rtc_pkg::ADDR_WEEKDAYS: day_of_week <= wr_data_in[2:0];
				rtc_pkg::ADDR_MONTHS: month_count <= wr_data_in[4:0];
				rtc_pkg::ADDR_YEARS: year_count <= wr_data_in;
				default: begin
				end
			endcase
		end else begin
			seconds_count <= next_seconds;
			minutes_count <= next_minutes;
			hours_count <= next_hours;
			day_of_month <= next_day;
			day_of_week <= next_weekday;
			month_count <= next_month;
			year_count <= next_year;
		end
	end

	// Free scratch byte, no side effects
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scratch_byte <= rtc_pkg::SCRATCH_RST;
		end else if (wr_en_in && addr_in == rtc_pkg::ADDR_SCRATCH) begin
			scratch_byte <= wr_data_in;
		end
	end

	// ==========================================================
	// Read data, one cycle after the address; unused bits read 0
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_data_out <= 8'h00;
		end else begin
			unique case (addr_in)
				rtc_pkg::ADDR_SCRATCH: rd_data_out <= scratch_byte;
				rtc_pkg::ADDR_SECONDS: rd_data_out <= {osc_stopped_flag_out, seconds_count};
				rtc_pkg::ADDR_MINUTES: rd_data_out <= {1'b0, minutes_count};
				rtc_pkg::ADDR_HOURS: rd_data_out <= {2'h0, hours_count};
				rtc_pkg::ADDR_DAYS: rd_data_out <= {2'h0, day_of_month};
				rtc_pkg::ADDR_WEEKDAYS: rd_data_out <= {5'h00, day_of_week};
				rtc_pkg::ADDR_MONTHS: rd_data_out <= {3'h0, month_count};
				rtc_pkg::ADDR_YEARS: rd_data_out <= year_count;
				default: rd_data_out <= 8'h00;
			endcase
		end
	end
endmodule : rtc_time_date_counters

// file: verification/rtc_counters_chk.sv
/*
 Checker of the time and date counter block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module rtc_counters_chk #(
	parameter int unsigned STOP_TIMEOUT = 40
) (
	// Clocks and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic osc_clk_in,
	// Register port and controls
	input wire logic wr_en_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [2:0] freq_output_pin_sel_in,
	input wire logic [1:0] timer_src_sel_in,
	// Pins
	input wire logic corr_int_n_out,
	input wire logic freq_output_pin_out,
	input wire logic timer_clk_out,
	input wire logic osc_stopped_flag_out
);
	// ==========================================
	// Helpers
	logic [15:0] low_run;
	logic [15:0] high_run;
	logic [15:0] quiet;
	logic osc_seen;
	logic clr_wr;
	// Run lengths of the pulse pin; high run saturates across idle seconds
	always_ff @(posedge osc_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			low_run <= 16'h0000;
			high_run <= 16'h0000;
		end else begin
			low_run <= corr_int_n_out ? 16'h0000 : low_run + 16'h0001;
			high_run <= !corr_int_n_out ? 16'h0000 : high_run + {15'h0000, ~&high_run};
		end
	end
	// System cycles since the oscillator line last moved
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			osc_seen <= 1'b0;
			quiet <= 16'h0000;
		end else begin
			osc_seen <= osc_clk_in;
			quiet <= (osc_seen != osc_clk_in) ? 16'h0000 : quiet + {15'h0000, ~&quiet};
		end
	end
	assign clr_wr = wr_en_in && addr_in == 8'h04 && !wr_data_in[7];
	sequence pulse_end;
		$rose(corr_int_n_out);
	endsequence
	sequence pulse_next;
		$fell(corr_int_n_out) && high_run < 16'h0040;
	endsequence
	// ==========================================
	// Assertions
	pulse_width_a: assert property (@(posedge osc_clk_in) disable iff (!rstn_in)
		pulse_end |-> low_run == 16'h0020) else $error("pulse width wrong");
	pulse_space_a: assert property (@(posedge osc_clk_in) disable iff (!rstn_in)
		pulse_next |-> high_run == 16'h0020) else $error("pulse spacing wrong");
	freq_off_a: assert property (@(posedge osc_clk_in) disable iff (!rstn_in)
		(freq_output_pin_sel_in == 3'h7) [*6] |=> !freq_output_pin_out) else $error("clock output not off");
	// Fastest timer source runs off the lower stage, so corrections never bend it
	tmr_fast_a: assert property (@(posedge osc_clk_in) disable iff (!rstn_in)
		(timer_src_sel_in == 2'h0) [*8] |-> timer_clk_out != $past(timer_clk_out, 4))
		else $error("timer fast rate bent");
	flag_init_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(rstn_in) |-> osc_stopped_flag_out) else $error("stop flag not set");
	flag_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(osc_stopped_flag_out) |-> $past(clr_wr) || $past(clr_wr, 2))
		else $error("stop flag fell without write");
	flag_stop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		quiet > STOP_TIMEOUT + 8 |-> osc_stopped_flag_out) else $error("stop flag missing");
	sec_bcd_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		addr_in == 8'h04 |=> rd_data_out[6:4] <= 3'h5 && rd_data_out[3:0] <= 4'h9)
		else $error("seconds not BCD");
	min_bits_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		addr_in == 8'h05 |=> !rd_data_out[7]) else $error("minutes bit7 set");
	hour_bits_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		addr_in == 8'h06 |=> rd_data_out[7:6] == 2'h0) else $error("hours upper bits set");
	wday_bits_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
		addr_in == 8'h08 |=> rd_data_out[7:3] == 5'h00 && rd_data_out[2:0] != 3'h7)
		else $error("weekday out of range");
endmodule : rtc_counters_chk
bind rtc_time_date_counters rtc_counters_chk #(.STOP_TIMEOUT(STOP_TIMEOUT)) chk_inst (
	.clk_in(clk_in), .rstn_in(rstn_in), .osc_clk_in(osc_clk_in), .wr_en_in(wr_en_in),
	.addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
	.freq_output_pin_sel_in(freq_output_pin_sel_in), .corr_int_n_out(corr_int_n_out),
	.timer_src_sel_in(timer_src_sel_in), .timer_clk_out(timer_clk_out),
	.freq_output_pin_out(freq_output_pin_out), .osc_stopped_flag_out(osc_stopped_flag_out)
);

// file: verification/host_bus_model.sv
/*
 Host side of the register port: byte writes and reads.
 Assumes its tasks are called from one process at a time.
*/
`timescale 1ns/1ps
module host_bus_model (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic access_active_out,
	output logic wr_en_out,
	output logic [7:0] addr_out,
	output logic [7:0] wr_data_out,
	input wire logic [7:0] rd_data_in,
	// Read answer settled for the bench
	output logic rd_strobe_out
);
	// ==========================================
	// Idle levels
	initial begin
		access_active_out = 1'b0;
		wr_en_out = 1'b0;
		addr_out = 8'h00;
		wr_data_out = 8'h00;
		rd_strobe_out = 1'b0;
	end
	// Access window; callers keep it well under one second
	task automatic hold(input logic on);
		@(posedge clk_in);
		#1 access_active_out = on;
	endtask : hold
	// Data line shows the inverse once the strobe is gone
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1 wr_en_out = 1'b1;
		addr_out = a;
		wr_data_out = d;
		@(posedge clk_in);
		#1 wr_en_out = 1'b0;
		wr_data_out = ~d;
	endtask : wr
	// Answer is registered one cycle after the address
	task automatic rd(input logic [7:0] a, input logic note, output logic [7:0] d);
		@(posedge clk_in);
		#1 addr_out = a;
		@(posedge clk_in);
		#1 d = rd_data_in;
		rd_strobe_out = note;
		@(posedge clk_in);
		#1 rd_strobe_out = 1'b0;
	endtask : rd
endmodule : host_bus_model

// file: verification/tb_rtc_time_date_counters.sv
/*
 Bench of the time and date counter block.
 Assumes the bound checker and the host model beside it.
*/
`timescale 1ns/1ps
module tb_rtc_time_date_counters;
	localparam int unsigned STOP_TO = 40;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic osc = 1'b0;
	logic osc_run = 1'b1;
	logic acc, wr_en, strobe, h12 = 1'b0, fast = 1'b1, sign = 1'b0;
	logic corr_n, freq, tmr, flag;
	logic [7:0] addr, wdata, rdata, rnd;
	logic [2:0] cnt = 3'h3, csel = 3'h7;
	logic [1:0] tsel = 2'h0;
	logic [7:0] exp_q[$];
	int num_errors = 0;
	int n_tests = 0;
	// ==========================================
	// Clocks; the oscillator stands still while stopped
	always #10 clk = ~clk;
	initial begin
		#1.3;
		forever #3 if (osc_run) osc = ~osc;
	end
	rtc_time_date_counters #(.STOP_TIMEOUT(STOP_TO)) rtc_time_date_counters_inst (
		.clk_in(clk), .rstn_in(rstn), .osc_clk_in(osc), .access_active_in(acc),
		.wr_en_in(wr_en), .addr_in(addr), .wr_data_in(wdata), .rd_data_out(rdata),
		.hour_12_mode_in(h12), .fast_mode_in(fast), .corr_count_in(cnt), .corr_sign_in(sign),
		.freq_output_pin_sel_in(csel), .timer_src_sel_in(tsel), .corr_int_n_out(corr_n),
		.freq_output_pin_out(freq), .timer_clk_out(tmr), .osc_stopped_flag_out(flag));
	host_bus_model host_bus_model_inst (.clk_in(clk), .access_active_out(acc),
		.wr_en_out(wr_en), .addr_out(addr), .wr_data_out(wdata), .rd_data_in(rdata),
		.rd_strobe_out(strobe));
	// ==========================================
	// Comparison and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	// Oldest note is taken mid-cycle, while the read answer stands settled
	always @(negedge clk) begin
		if (strobe && exp_q.size() > 0) begin
			check(rdata, exp_q.pop_front());
		end
	end
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] want);
		logic [7:0] d;
		exp_q.push_back(want);
		host_bus_model_inst.rd(a, 1'b1, d);
	endtask : rd_exp
	// Bounded poll until seconds leave 59
	task automatic wait_tick();
		logic [7:0] d;
		d = 8'h59;
		for (int i = 0; i < 5000 && d[6:0] === 7'h59; i++) begin
			host_bus_model_inst.rd(8'h04, 1'b0, d);
		end
		if (d[6:0] !== 7'h00) begin
			num_errors++;
			close_out();
		end
	endtask : wait_tick
	// Set 0Ah down to 04h in one access, wait one tick, read all back
	task automatic run_case(input logic [55:0] set, input logic [55:0] want);
		host_bus_model_inst.hold(1'b1);
		for (int i = 6; i >= 0; i--) host_bus_model_inst.wr(8'h04 + 8'(i), set[8 * i +: 8]);
		host_bus_model_inst.hold(1'b0);
		wait_tick();
		for (int i = 0; i < 7; i++) rd_exp(8'h04 + 8'(i), want[8 * i +: 8]);
		$display("test calendar case done");
	endtask : run_case
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hD8E1));
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		for (int i = 0; i < 10; i++) rd_exp(8'h02 + 8'(i),
			8'(80'h00_00_80_00_00_01_06_01_00_00 >> 8 * (9 - i)));
		$display("test reset values done");
		rnd = 8'($urandom);
		host_bus_model_inst.wr(8'h03, rnd);
		rd_exp(8'h03, rnd);
		host_bus_model_inst.wr(8'h0B, rnd);
		rd_exp(8'h0B, 8'h00);
		$display("test scratch done");
		cnt = 3'($urandom_range(7, 1));
		sign = 1'($urandom);
		csel = 3'($urandom_range(6, 0));
		run_case(56'h04_02_06_28_23_59_59, 56'h04_02_00_29_00_00_00);
		// Flag is clear here, so the stop really has to set it again
		osc_run = 1'b0;
		repeat (STOP_TO + 20) @(posedge clk);
		host_bus_model_inst.wr(8'h04, 8'h00);
		rd_exp(8'h04, 8'h80);
		osc_run = 1'b1;
		repeat (STOP_TO + 20) @(posedge clk);
		rd_exp(8'h04, 8'h80);
		$display("test stop flag done");
		@(posedge clk);
		#1 h12 = 1'b1;
		tsel = 2'($urandom);
		run_case(56'h04_02_05_29_31_59_59, 56'h04_03_06_01_12_00_00);
		@(posedge clk);
		#1 h12 = 1'b0;
		run_case(56'h99_12_03_31_23_59_59, 56'h00_01_04_01_00_00_00);
		close_out();
	end
endmodule : tb_rtc_time_date_counters
